// ===== inc/gtfc_pkg.sv
// Shared constants and carrier types for the general timer and free counter.
package gtfc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;

  // Register byte addresses.
  localparam logic [ADDR_W-1:0] GT_CONFIG_ADDR  = 8'h8C;
  localparam logic [ADDR_W-1:0] GT_COUNT_ADDR   = 8'h90;
  localparam logic [ADDR_W-1:0] FREE_RUN_ADDR   = 8'h9C;
  localparam logic [ADDR_W-1:0] FREE_HOLD_ADDR  = 8'hA0;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 8'hA4;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR   = 8'hA8;

  // Field layout of the configuration register, counter widths and reset values.
  localparam int CFG_EN_BIT  = 29;
  localparam int PRELOAD_W   = 16;
  localparam int FREE_W      = 32;
  localparam logic [PRELOAD_W-1:0] PRELOAD_ALL_ONES = 16'hFFFF;
  localparam logic [PRELOAD_W-1:0] COUNT_RESET      = 16'hFFFF;
  localparam logic [FREE_W-1:0]    FREE_RESET       = 32'h00000000;
  localparam logic [FREE_W-1:0]    FREE_MAX         = 32'hFFFFFFFF;

  // Interrupt status and mask layout.
  localparam int IRQ_W          = 2;
  localparam int IRQ_TIMER_BIT  = 0;
  localparam int IRQ_WRAP_BIT   = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // Timing.
  localparam int CLK_PERIOD_NS     = 40;
  localparam int FREE_CLEAR_NS     = 160;
  localparam int FREE_CLEAR_CYCLES = FREE_CLEAR_NS / CLK_PERIOD_NS;
  localparam int TICK_CYCLES_DEFAULT = 25;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [STRB_W-1:0] strb;
  } gtfc_wr_req_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
  } gtfc_rd_req_type;

  typedef enum logic {
    TMR_HALTED  = 1'b0,
    TMR_RUNNING = 1'b1
  } gtfc_timer_state_type;

endpackage

// ===== sim/gtfc_host_model.sv
// Host processor model: an AXI4-Lite master with optional response stalls.
`timescale 1ns/100ps
module gtfc_host_model (
  input  wire logic                        aclk,
  output logic [gtfc_pkg::ADDR_W-1:0]      s_axi_awaddr,
  output logic                             s_axi_awvalid,
  input  wire logic                        s_axi_awready,
  output logic [gtfc_pkg::DATA_W-1:0]      s_axi_wdata,
  output logic [gtfc_pkg::STRB_W-1:0]      s_axi_wstrb,
  output logic                             s_axi_wvalid,
  input  wire logic                        s_axi_wready,
  input  wire logic [1:0]                  s_axi_bresp,
  input  wire logic                        s_axi_bvalid,
  output logic                             s_axi_bready,
  output logic [gtfc_pkg::ADDR_W-1:0]      s_axi_araddr,
  output logic                             s_axi_arvalid,
  input  wire logic                        s_axi_arready,
  input  wire logic [gtfc_pkg::DATA_W-1:0] s_axi_rdata,
  input  wire logic [1:0]                  s_axi_rresp,
  input  wire logic                        s_axi_rvalid,
  output logic                             s_axi_rready
);
  import gtfc_pkg::*;
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
  end
  // Released addresses and write data are inverted so a slave cannot lean on stale values; the strobe is left as driven.
  task automatic write(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic [3:0] s, input int stall,
                       output logic [1:0] resp, output bit ok);
    @(posedge aclk);
    ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (stall == 0);
    for (int n = 0; n < 300 && !ok; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bready && s_axi_bvalid) begin
        resp = s_axi_bresp;
        ok = 1'b1;
        s_axi_bready <= 1'b0;
      end else if (n + 1 >= stall) begin
        s_axi_bready <= 1'b1;
      end
    end
  endtask
  task automatic read(input logic [ADDR_W-1:0] a, input int stall,
                      output logic [31:0] d, output logic [1:0] resp,
                      output time t, output bit ok);
    @(posedge aclk);
    ok = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (stall == 0);
    for (int n = 0; n < 300 && !ok; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        t = $time;
      end
      if (s_axi_rready && s_axi_rvalid) begin
        d = s_axi_rdata;
        resp = s_axi_rresp;
        ok = 1'b1;
        s_axi_rready <= 1'b0;
      end else if (n + 1 >= stall) begin
        s_axi_rready <= 1'b1;
      end
    end
  endtask
endmodule

// ===== sim/gtfc_timer_checker.sv
// Port-level assertions for the timer block and its register bus.
`timescale 1ns/100ps
module gtfc_timer_checker #(
  parameter int TICK_CYCLES = gtfc_pkg::TICK_CYCLES_DEFAULT
) (
  input wire logic                        aclk,
  input wire logic                        aresetn,
  input wire logic                        s_axi_awvalid,
  input wire logic                        s_axi_awready,
  input wire logic                        s_axi_wvalid,
  input wire logic                        s_axi_wready,
  input wire logic [1:0]                  s_axi_bresp,
  input wire logic                        s_axi_bvalid,
  input wire logic                        s_axi_bready,
  input wire logic [gtfc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic [gtfc_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]                  s_axi_rresp,
  input wire logic                        s_axi_rvalid,
  input wire logic                        s_axi_rready,
  input wire logic                        irq
);
  import gtfc_pkg::*;
  logic [ADDR_W-1:0] rd_addr;
  logic              mapped;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // The read address is kept so that read data can be judged by register.
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_addr <= s_axi_araddr;
    end
  end
  assign mapped = rd_addr inside {GT_CONFIG_ADDR, GT_COUNT_ADDR,
    FREE_RUN_ADDR, FREE_HOLD_ADDR, IRQ_STATUS_ADDR, IRQ_MASK_ADDR};
  a_aw_busy: assert property (s_axi_awvalid && s_axi_awready
    |=> !s_axi_awready) else $error("write address taken twice");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read response late");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
  a_ar_held: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  a_count_rsvd: assert property (
    s_axi_rvalid && rd_addr == GT_COUNT_ADDR
    |-> s_axi_rdata[31:16] == 16'h0000) else $error("count upper bits");
  a_config_rsvd: assert property (
    s_axi_rvalid && rd_addr == GT_CONFIG_ADDR
    |-> s_axi_rdata[31:30] == 2'h0 && s_axi_rdata[28:16] == 13'h0000)
    else $error("config reserved bits");
  a_unmapped_err: assert property (s_axi_rvalid && !mapped
    |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == DATA_ZERO)
    else $error("unmapped read answer");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && !mapped);
  cover property ($rose(irq));
endmodule
bind gtfc_timer_top gtfc_timer_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.*);

// ===== sim/testbench.sv
// Self-checking bench for the general timer and free counter.
`timescale 1ns/100ps
module testbench;
  import gtfc_pkg::*;
  logic aclk, aresetn, irq;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [STRB_W-1:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int mismatches = 0;
  int n_compared = 0;
  logic [15:0] lfsr = 16'hECF3;
  localparam logic [7:0] RST_ADDR [4] = '{GT_CONFIG_ADDR, GT_COUNT_ADDR,
    IRQ_STATUS_ADDR, IRQ_MASK_ADDR};
  localparam logic [31:0] RST_VAL [4] = '{32'h0000FFFF, 32'h0000FFFF,
    32'h00000000, 32'h00000000};
  gtfc_timer_top #(.TICK_CYCLES(2)) dut_u (.*);
  gtfc_host_model host_u (.*);
  initial aclk = 1'b0;
  always #20 aclk = ~aclk;
  function automatic logic [15:0] next_rand(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [31:0] cfg_word(input logic en,
                                           input logic [15:0] p);
    return {2'h0, en, 13'h0000, p};
  endfunction
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_rng(input logic [31:0] got, lo, hi);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic give_up();
    mismatches++;
    summarize();
  endtask
  // Stall lengths are random so the slave sees both prompt and slow hosts.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    bit ok;
    lfsr = next_rand(lfsr);
    host_u.write(a, d, 4'hF, int'(lfsr[1:0]), r, ok);
    if (!ok) give_up();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r, output time t);
    bit ok;
    lfsr = next_rand(lfsr);
    host_u.read(a, int'(lfsr[1:0]), d, r, t, ok);
    if (!ok) give_up();
  endtask
  task automatic wait_irq(output int k);
    for (k = 0; k < 60 && irq !== 1'b1; k++) @(posedge aclk);
    if (k == 60) give_up();
  endtask
  initial begin
    logic [31:0] v, w, p, d;
    logic [1:0] r;
    time t0, t1, t2;
    int k;
    aresetn = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t0 = $time;
    repeat (FREE_CLEAR_CYCLES) @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      rd(RST_ADDR[i], v, r, t1);
      check_eq(v, RST_VAL[i]);
      check_eq(32'(r), 32'(RESP_OKAY));
    end
    rd(FREE_RUN_ADDR, v, r, t1);
    // The counter restarts at the edge after release; allow the clear delay.
    d = 32'((t1 - t0) / CLK_PERIOD_NS) - 32'h1;
    check_rng(v, d - 32'(FREE_CLEAR_CYCLES), d);
    rd(FREE_HOLD_ADDR, w, r, t2);
    check_eq(w, v);
    rd(FREE_RUN_ADDR, w, r, t2);
    check_eq(w - v, 32'((t2 - t1) / 40));
    rd(8'h40, v, r, t1);
    check_eq(v, DATA_ZERO);
    check_eq(32'(r), 32'(RESP_SLVERR));
    wr(8'h44, 32'h0, r);
    check_eq(32'(r), 32'(RESP_SLVERR));
    wr(GT_COUNT_ADDR, 32'h0, r);
    check_eq(32'(r), 32'(RESP_OKAY));
    rd(GT_COUNT_ADDR, v, r, t1);
    check_eq(v, 32'h0000FFFF);
    wr(GT_CONFIG_ADDR, 32'hDFFF1234, r);
    rd(GT_CONFIG_ADDR, v, r, t1);
    check_eq(v, 32'h00001234);
    repeat (3) begin
      lfsr = next_rand(lfsr);
      p = {16'h0000, 1'b1, lfsr[14:0]};
      wr(GT_CONFIG_ADDR, cfg_word(1'b1, p[15:0]), r);
      rd(GT_COUNT_ADDR, v, r, t1);
      check_rng(v, p - 40, p);
      rd(GT_COUNT_ADDR, w, r, t2);
      d = 32'((t2 - t1) / 40);
      check_rng(w, v - (d + 1) / 2, v - d / 2);
      wr(GT_CONFIG_ADDR, cfg_word(1'b0, p[15:0]), r);
      rd(GT_CONFIG_ADDR, v, r, t1);
      check_eq(v, 32'h0000FFFF);
      rd(GT_COUNT_ADDR, v, r, t1);
      rd(GT_COUNT_ADDR, w, r, t2);
      check_eq(w, v);
    end
    wr(GT_CONFIG_ADDR, cfg_word(1'b1, 16'h0003), r);
    repeat (20) @(posedge aclk);
    check_eq(32'(irq), 32'h0);
    wr(IRQ_MASK_ADDR, 32'h1, r);
    rd(IRQ_STATUS_ADDR, v, r, t1);
    check_eq(v & 32'h1, 32'h1);
    wait_irq(k);
    check_eq(32'(irq), 32'h1);
    rd(IRQ_STATUS_ADDR, v, r, t1);
    wait_irq(k);
    check_rng(32'(k), 32'h0, 32'h8);
    wr(GT_CONFIG_ADDR, cfg_word(1'b0, 16'h0003), r);
    rd(IRQ_STATUS_ADDR, v, r, t1);
    repeat (2) @(posedge aclk);
    check_eq(32'(irq), 32'h0);
    rd(IRQ_STATUS_ADDR, v, r, t1);
    check_eq(v, DATA_ZERO);
    summarize();
  end
endmodule

// ===== src/gtfc_axil_slave.sv
// AXI4-Lite slave front end that turns bus transfers into register strobes.
`timescale 1ns/100ps
module gtfc_axil_slave (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [gtfc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [gtfc_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [gtfc_pkg::STRB_W-1:0] s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [gtfc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [gtfc_pkg::DATA_W-1:0]    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic                           wr_fire,
  output gtfc_pkg::gtfc_wr_req_type      wr_req,
  input  wire logic                      wr_err,
  output logic                           rd_fire,
  output gtfc_pkg::gtfc_rd_req_type      rd_req,
  input  wire logic [gtfc_pkg::DATA_W-1:0] rd_data,
  input  wire logic                      rd_err
);
  import gtfc_pkg::*;

  logic aw_held;
  logic w_held;

  // A write is performed once both halves are held and no response waits.
  assign wr_fire     = aw_held && w_held && !s_axi_bvalid;
  assign rd_fire     = s_axi_arvalid && s_axi_arready;
  assign rd_req.addr = s_axi_araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      s_axi_awready <= 1'b1;
      wr_req.addr   <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held       <= 1'b1;
      s_axi_awready <= 1'b0;
      wr_req.addr   <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held       <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held       <= 1'b0;
      s_axi_wready <= 1'b1;
      wr_req.data  <= DATA_ZERO;
      wr_req.strb  <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held       <= 1'b1;
      s_axi_wready <= 1'b0;
      wr_req.data  <= s_axi_wdata;
      wr_req.strb  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held       <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read data is sampled in the same edge that takes the address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rdata   <= DATA_ZERO;
      s_axi_rresp   <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid  <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ===== src/gtfc_timer_top.sv
// General purpose down timer and free-running up counter behind AXI4-Lite.
//
// Overview of operation
// - Timer counts while its enable bit is set and halts while clear.
// - Clearing the enable bit from one forces the preload field to FFFFh.
// - On enable the timer loads the preload value and decrements from it.
// - The timer can raise a periodic host interrupt set by the preload.
// - Read-only count field shows the present timer value; FFFFh after reset.
// - Free counter starts at zero after reset and adds one every cycle.
// - Free counter wraps from its maximum to zero and keeps counting.
// - Each read of the free count captures it; reads of the hold word return the capture.
// - Free counter may need up to 160 ns to show zero after reset.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
module gtfc_timer_top #(
  parameter int TICK_CYCLES = gtfc_pkg::TICK_CYCLES_DEFAULT
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [gtfc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [gtfc_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [gtfc_pkg::STRB_W-1:0] s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [gtfc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [gtfc_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic                             irq
);
  import gtfc_pkg::*;

  localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  // Register bus strobes.
  logic                  wr_fire;
  gtfc_wr_req_type       wr_req;
  logic                  wr_err;
  logic                  rd_fire;
  gtfc_rd_req_type       rd_req;
  logic [DATA_W-1:0]     rd_data;
  logic                  rd_err;

  // Software visible state.
  logic                  timer_enable;
  logic [PRELOAD_W-1:0]  timer_preload_value;
  logic [PRELOAD_W-1:0]  general_timer;
  logic [FREE_W-1:0]     free_count_value;
  logic [FREE_W-1:0]     free_count_hold;
  logic [IRQ_W-1:0]      irq_status;
  logic [IRQ_W-1:0]      irq_mask;

  // Timer internals.
  gtfc_timer_state_type  timer_state;
  logic [TICK_W-1:0]     tick_count;
  logic                  tick;
  logic                  timer_event;
  logic                  wrap_event;
  logic [IRQ_W-1:0]      irq_events;

  // Decoded write and read intents.
  logic                  cfg_write;
  logic                  mask_write;
  logic [DATA_W-1:0]     cfg_merged;
  logic                  next_enable;
  logic                  status_read;
  logic                  free_read;

  // Applies byte strobes to an old register image.
  function automatic logic [DATA_W-1:0] apply_strb(
    input logic [DATA_W-1:0] old_value,
    input logic [DATA_W-1:0] new_value,
    input logic [STRB_W-1:0] strb
  );
    logic [DATA_W-1:0] result;
    result = old_value;
    for (int i = 0; i < STRB_W; i++) begin
      if (strb[i]) begin
        result[i*8 +: 8] = new_value[i*8 +: 8];
      end
    end
    return result;
  endfunction

  // True for any address that holds a register.
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
    logic hit;
    hit = 1'b0;
    if (addr == GT_CONFIG_ADDR) begin
      hit = 1'b1;
    end else if (addr == GT_COUNT_ADDR) begin
      hit = 1'b1;
    end else if (addr == FREE_RUN_ADDR) begin
      hit = 1'b1;
    end else if (addr == FREE_HOLD_ADDR) begin
      hit = 1'b1;
    end else if (addr == IRQ_STATUS_ADDR) begin
      hit = 1'b1;
    end else if (addr == IRQ_MASK_ADDR) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  gtfc_axil_slave u_slave (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_fire       (wr_fire),
    .wr_req        (wr_req),
    .wr_err        (wr_err),
    .rd_fire       (rd_fire),
    .rd_req        (rd_req),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  // Write decode. Read-only registers accept writes silently.
  always_comb begin
    wr_err     = !addr_mapped(wr_req.addr);
    cfg_write  = wr_fire && (wr_req.addr == GT_CONFIG_ADDR);
    mask_write = wr_fire && (wr_req.addr == IRQ_MASK_ADDR);
    cfg_merged = apply_strb({2'h0, timer_enable, 13'h0000,
                             timer_preload_value},
                            wr_req.data, wr_req.strb);
    next_enable = cfg_write ? cfg_merged[CFG_EN_BIT] : timer_enable;
  end

  always_comb begin
    status_read = rd_fire && (rd_req.addr == IRQ_STATUS_ADDR);
    free_read   = rd_fire && (rd_req.addr == FREE_RUN_ADDR);
  end

  // Configuration register; only the enable bit and preload are kept.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_enable <= 1'b0;
    end else if (cfg_write) begin
      timer_enable <= next_enable;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_preload_value <= PRELOAD_ALL_ONES;
    end else if (cfg_write && timer_enable && !next_enable) begin
      // The preset overrides any preload written in the same access.
      timer_preload_value <= PRELOAD_ALL_ONES;
    end else if (cfg_write) begin
      timer_preload_value <= cfg_merged[PRELOAD_W-1:0];
    end
  end

  // Prescaler: one tick enable per TICK_CYCLES clocks while running.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_count <= '0;
    end else if (timer_state != TMR_RUNNING || !timer_enable) begin
      tick_count <= '0;
    end else if (tick_count == TICK_LAST) begin
      tick_count <= '0;
    end else begin
      tick_count <= tick_count + TICK_W'(1);
    end
  end

  assign tick = (timer_state == TMR_RUNNING) && timer_enable &&
                (tick_count == TICK_LAST);

  // Halted keeps the count frozen; entering run reloads from preload.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_state   <= TMR_HALTED;
      general_timer <= COUNT_RESET;
    end else begin
      case (timer_state)
        TMR_HALTED: begin
          if (timer_enable) begin
            timer_state   <= TMR_RUNNING;
            general_timer <= timer_preload_value;
          end
        end
        TMR_RUNNING: begin
          if (!timer_enable) begin
            timer_state <= TMR_HALTED;
          end else if (tick && general_timer == '0) begin
            general_timer <= timer_preload_value;
          end else if (tick) begin
            general_timer <= general_timer - PRELOAD_W'(1);
          end
        end
        default: begin
          timer_state <= TMR_HALTED;
        end
      endcase
    end
  end

  assign timer_event = tick && (general_timer == '0);

  // Free counter clears on the first reset edge, well inside the
  // FREE_CLEAR_CYCLES allowance a host must wait before trusting zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      free_count_value <= FREE_RESET;
    end else begin
      free_count_value <= free_count_value + FREE_W'(1);
    end
  end

  assign wrap_event = (free_count_value == FREE_MAX);

  // A full word read of the live counter also freezes the value, so a
  // host that then reads the halves through the hold word sees one sample.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      free_count_hold <= FREE_RESET;
    end else if (free_read) begin
      free_count_hold <= free_count_value;
    end
  end

  // Sticky status: an event in the clearing cycle survives the clear.
  assign irq_events = {wrap_event, timer_event};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= IRQ_RESET;
    end else if (status_read) begin
      irq_status <= irq_events;
    end else begin
      irq_status <= irq_status | irq_events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= IRQ_RESET;
    end else if (mask_write && wr_req.strb[0]) begin
      irq_mask <= wr_req.data[IRQ_W-1:0];
    end
  end

  // Registered from the next status so the line tracks without lag.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else if (status_read) begin
      irq <= |(irq_events & irq_mask);
    end else begin
      irq <= |((irq_status | irq_events) & irq_mask);
    end
  end

  // Read mux; reserved bits return zero.
  always_comb begin
    rd_err  = !addr_mapped(rd_req.addr);
    rd_data = DATA_ZERO;
    if (rd_req.addr == GT_CONFIG_ADDR) begin
      rd_data = {2'h0, timer_enable, 13'h0000, timer_preload_value};
    end else if (rd_req.addr == GT_COUNT_ADDR) begin
      rd_data = {16'h0000, general_timer};
    end else if (rd_req.addr == FREE_RUN_ADDR) begin
      rd_data = free_count_value;
    end else if (rd_req.addr == FREE_HOLD_ADDR) begin
      rd_data = free_count_hold;
    end else if (rd_req.addr == IRQ_STATUS_ADDR) begin
      rd_data = {{(DATA_W-IRQ_W){1'b0}}, irq_status};
    end else if (rd_req.addr == IRQ_MASK_ADDR) begin
      rd_data = {{(DATA_W-IRQ_W){1'b0}}, irq_mask};
    end
  end

endmodule
